// ==== inc/qds_sram_regs.vh ====
// constants for the burst-of-four ddr sram read and write ports
// assumes: included by bare name from the port module under verilog/
//
// How it works
// - read-select low at a true-clock rise captures the address, starts a read
// - each low byte-lane enable writes its byte; sampled with its beat
// - free-running echo clocks toggle exactly with the read data outputs
// - read beats on true rise two cycles later, then comp, true, comp
// - read-select high is a no-op and never cuts a running read short
// - write-select low at a true rise starts a write, address same edge
// - write beats: true rise one cycle later, then comp, true, comp
// - write data sits in buffers; committed to array on third write
// - reads of the two latest write addresses come from the buffers
// - byte enables act per byte of each of the four burst addresses
// - write-select high at a true rise leaves memory untouched
// - burst addresses are base, base+1, base+2, base+3, linear
// - read and write machines run independently and concurrently
`ifndef QDS_SRAM_REGS_VH
`define QDS_SRAM_REGS_VH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define QDS_ADDR_W 19
`define QDS_DATA_W 36
`define QDS_LANES 4
`define QDS_BURST 4

// ----------------------------------------------------------------
// timing in true-clock rises
// ----------------------------------------------------------------
`define QDS_RD_LAT_K 2
`define QDS_WR_LAT_K 1

// ----------------------------------------------------------------
// buffering
// ----------------------------------------------------------------
`define QDS_FIFO_DEPTH 32
`define QDS_FIFO_PTR_W 5

`endif

// ==== verilog/qds_mem.v ====
// storage array with byte-lane writes and a registered read port
// assumes: one write and one read per clock, read data one cycle later
`timescale 1ns/1ps
module qds_mem #(
   parameter AW = 19,
   parameter DW = 36,
   parameter LN = 4
) (
   input wire mclk, // system clock
   input wire we, // write strobe
   input wire [AW-1:0] waddr, // write address
   input wire [DW-1:0] wdata, // write data
   input wire [LN-1:0] wbe, // byte lane enables, high writes
   input wire [AW-1:0] raddr, // read address
   output reg [DW-1:0] rdata // registered read data
);
   localparam BYW = DW / LN;
   reg [DW-1:0] arr [0:(1<<AW)-1];
   integer l;

   // ----------------------------------------------------------------
   // write and read ports
   // ----------------------------------------------------------------
   // only enabled lanes change
   always @(posedge mclk) begin
      if (we) begin
         for (l = 0; l < LN; l = l + 1) begin
            if (wbe[l]) begin
               arr[waddr][l*BYW +: BYW] <= wdata[l*BYW +: BYW];
            end
         end
      end
      rdata <= arr[raddr];
   end
endmodule // qds_mem

// ==== verilog/qds_fifo.v ====
// read-beat fifo between the array lookup and the output stage
// assumes: same clock on both sides, depth a power of two
`timescale 1ns/1ps
module qds_fifo #(
   parameter WIDTH = 36,
   parameter DEPTH = 32,
   parameter PW = 5
) (
   input wire mclk, // system clock
   input wire resetn, // async reset, active low
   input wire in_valid, // push request
   output wire in_ready, // room for a word
   input wire [WIDTH-1:0] in_data, // pushed word
   output wire out_valid, // word available
   input wire out_ready, // pop request
   output wire [WIDTH-1:0] out_data // head word
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [PW-1:0] wp;
   reg [PW-1:0] rp;
   reg [PW:0] cnt;
   wire push;
   wire pop;

   // ----------------------------------------------------------------
   // handshakes
   // ----------------------------------------------------------------
   assign in_ready = (cnt != DEPTH[PW:0]);
   assign out_valid = (cnt != {(PW+1){1'b0}});
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rp];

   // storage
   always @(posedge mclk) begin
      if (push) begin
         mem[wp] <= in_data;
      end
   end

   // pointers and fill level
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wp <= {PW{1'b0}};
         rp <= {PW{1'b0}};
         cnt <= {(PW+1){1'b0}};
      end else begin
         if (push) begin
            wp <= wp + 1'b1;
         end
         if (pop) begin
            rp <= rp + 1'b1;
         end
         if (push && !pop) begin
            cnt <= cnt + 1'b1;
         end else if (pop && !push) begin
            cnt <= cnt - 1'b1;
         end
      end
   end
endmodule // qds_fifo

// ==== verilog/qds_sram_ports.v ====
// read and write ports of a ddr burst-of-four sram, sampled on mclk
// assumes: all pins are asynchronous to mclk; mclk much faster than k
`timescale 1ns/1ps
`include "qds_sram_regs.vh"
module qds_sram_ports #(
   parameter AW = `QDS_ADDR_W,
   parameter DW = `QDS_DATA_W,
   parameter LN = `QDS_LANES,
   parameter FDEPTH = `QDS_FIFO_DEPTH,
   parameter FPW = `QDS_FIFO_PTR_W
) (
   input wire mclk, // system clock
   input wire resetn, // async reset, active low
   input wire k_clk, // true input clock pin
   input wire k_clk_n, // complement input clock pin
   input wire read_sel_n, // read select, low active
   input wire write_sel_n, // write select, low active
   input wire [AW-1:0] sync_address_in, // command address
   input wire [DW-1:0] write_data_in, // write beat data
   input wire [LN-1:0] byte_lane_write_n, // byte write enables, low
   output reg [DW-1:0] read_data_out, // read beat data
   output reg echo_clock_true, // echo clock, in phase with k
   output reg echo_clock_comp // echo clock, in phase with k_n
);
   localparam BYW = DW / LN;
   localparam SW = 4 + AW + DW + LN;
   localparam RL = `QDS_RD_LAT_K;

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------
   // overlay one buffered burst on a word read for address a
   function [DW-1:0] ovl;
      input [DW-1:0] cur;
      input [AW-1:0] a;
      input sv;
      input [AW-1:0] sa;
      input [4*DW-1:0] sd;
      input [4*LN-1:0] sm;
      reg [AW-1:0] off;
      integer l;
      begin
         ovl = cur;
         off = a - sa;
         if (sv && off[AW-1:2] == {(AW-2){1'b0}}) begin
            for (l = 0; l < LN; l = l + 1) begin
               if (sm[off[1:0]*LN + l]) begin
                  ovl[l*BYW +: BYW] = sd[off[1:0]*DW + l*BYW +: BYW];
               end
            end
         end
      end
   endfunction

   // place one beat of data into a burst slot
   function [4*DW-1:0] put_d;
      input [4*DW-1:0] d;
      input [1:0] idx;
      input [DW-1:0] v;
      begin
         put_d = d;
         put_d[idx*DW +: DW] = v;
      end
   endfunction

   // place one beat of lane enables into a burst slot
   function [4*LN-1:0] put_m;
      input [4*LN-1:0] m;
      input [1:0] idx;
      input [LN-1:0] v;
      begin
         put_m = m;
         put_m[idx*LN +: LN] = v;
      end
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   reg [SW-1:0] sy1;
   reg [SW-1:0] sy2;
   reg [SW-1:0] sy3;
   reg k_lvl;
   reg kn_lvl;

   // three stages; selects reset to the idle level
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sy1 <= {SW{1'b1}};
         sy2 <= {SW{1'b1}};
         sy3 <= {SW{1'b1}};
      end else begin
         sy1 <= {k_clk, k_clk_n, read_sel_n, write_sel_n,
                 sync_address_in, write_data_in, byte_lane_write_n};
         sy2 <= sy1;
         sy3 <= sy2;
      end
   end

   wire k2 = sy2[SW-1];
   wire k3 = sy3[SW-1];
   wire kn2 = sy2[SW-2];
   wire kn3 = sy3[SW-2];
   wire rsel_n = sy3[SW-3];
   wire wsel_n = sy3[SW-4];
   wire [AW-1:0] s_addr = sy3[DW+LN +: AW];
   wire [DW-1:0] s_data = sy3[LN +: DW];
   wire [LN-1:0] s_bw_n = sy3[LN-1:0];

   // a level counts once stages two and three agree
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         k_lvl <= 1'b1;
         kn_lvl <= 1'b1;
      end else begin
         if (k2 == k3) begin
            k_lvl <= k3;
         end
         if (kn2 == kn3) begin
            kn_lvl <= kn3;
         end
      end
   end

   wire k_rise = k2 & k3 & ~k_lvl;
   wire kn_rise = kn2 & kn3 & ~kn_lvl;
   wire rd_cmd = k_rise & ~rsel_n;
   wire wr_cmd = k_rise & ~wsel_n;

   // ----------------------------------------------------------------
   // write buffers and commit
   // ----------------------------------------------------------------
   reg [AW-1:0] s0_a, s1_a, s2_a;
   reg [4*DW-1:0] s0_d, s1_d, s2_d;
   reg [4*LN-1:0] s0_m, s1_m, s2_m;
   reg s0_v, s1_v, s2_v;
   reg [2:0] cm_cnt;
   reg wsh;
   reg fill_on;
   reg [1:0] fill_n;
   reg fill_in1;

   // beat capture: first on a true rise, then comp, true, comp
   wire cap_first = k_rise & wsh;
   wire cap_more = fill_on & ((k_rise & fill_n == 2'd2) |
                   (kn_rise & (fill_n == 2'd1 | fill_n == 2'd3)));
   wire cap = cap_first | cap_more;
   wire [1:0] cap_idx = cap_first ? 2'd0 : fill_n;
   wire cap_to1 = cap_more & (fill_in1 | wr_cmd);
   wire [LN-1:0] cap_en = ~s_bw_n;

   // commit port drives the array one beat per cycle
   wire [1:0] cm_idx = 2'd0 - cm_cnt[1:0];
   wire cm_we = (cm_cnt != 3'd0);
   wire [AW-1:0] cm_addr = s2_a + {{(AW-2){1'b0}}, cm_idx};
   wire [DW-1:0] cm_data = s2_d[cm_idx*DW +: DW];
   wire [LN-1:0] cm_be = s2_m[cm_idx*LN +: LN];

   // buffer shifting, beat capture and commit sequencing
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s0_a <= {AW{1'b0}};
         s1_a <= {AW{1'b0}};
         s2_a <= {AW{1'b0}};
         s0_d <= {(4*DW){1'b0}};
         s1_d <= {(4*DW){1'b0}};
         s2_d <= {(4*DW){1'b0}};
         s0_m <= {(4*LN){1'b0}};
         s1_m <= {(4*LN){1'b0}};
         s2_m <= {(4*LN){1'b0}};
         s0_v <= 1'b0;
         s1_v <= 1'b0;
         s2_v <= 1'b0;
         cm_cnt <= 3'd0;
         wsh <= 1'b0;
         fill_on <= 1'b0;
         fill_n <= 2'd0;
         fill_in1 <= 1'b0;
      end else begin
         if (k_rise) begin
            wsh <= wr_cmd;
         end
         // a new write pushes the oldest buffer to the array
         if (wr_cmd) begin
            s0_a <= s_addr;
            s0_m <= {(4*LN){1'b0}};
            s0_v <= 1'b1;
            s1_a <= s0_a;
            s1_v <= s0_v;
            if (cap) begin
               s1_d <= put_d(s0_d, cap_idx, s_data);
               s1_m <= put_m(s0_m, cap_idx, cap_en);
            end else begin
               s1_d <= s0_d;
               s1_m <= s0_m;
            end
            if (s1_v) begin
               s2_a <= s1_a;
               s2_d <= s1_d;
               s2_m <= s1_m;
               s2_v <= 1'b1;
               cm_cnt <= 3'd4;
            end
            if (fill_on) begin
               fill_in1 <= 1'b1;
            end
         end else if (cap & cap_to1) begin
            s1_d <= put_d(s1_d, cap_idx, s_data);
            s1_m <= put_m(s1_m, cap_idx, cap_en);
         end else if (cap) begin
            s0_d <= put_d(s0_d, cap_idx, s_data);
            s0_m <= put_m(s0_m, cap_idx, cap_en);
         end
         if (!(wr_cmd & s1_v)) begin
            if (cm_cnt != 3'd0) begin
               cm_cnt <= cm_cnt - 3'd1;
            end else begin
               s2_v <= 1'b0;
            end
         end
         // beat counter for the burst being filled
         if (cap_first) begin
            fill_on <= 1'b1;
            fill_n <= 2'd1;
            fill_in1 <= 1'b0;
         end else if (cap_more) begin
            fill_n <= fill_n + 2'd1;
            if (fill_n == 2'd3) begin
               fill_on <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // read lookup into the fifo
   // ----------------------------------------------------------------
   reg [AW-1:0] rd_base;
   reg [2:0] iss_left;
   reg [1:0] iss_idx;
   reg pend;
   reg [AW-1:0] pend_addr;
   wire [DW-1:0] mem_rdata;
   wire f_in_ready;
   wire f_out_valid;
   wire [DW-1:0] f_out_data;
   wire iss = (iss_left != 3'd0) & f_in_ready & ~pend;
   wire [AW-1:0] rd_addr = rd_base + {{(AW-2){1'b0}}, iss_idx};
   // newest buffer applied last so it wins
   wire [DW-1:0] merged = ovl(ovl(ovl(mem_rdata, pend_addr, s2_v, s2_a,
                          s2_d, s2_m), pend_addr, s1_v, s1_a, s1_d, s1_m),
                          pend_addr, s0_v, s0_a, s0_d, s0_m);

   // one lookup in flight; a full fifo stalls the lookup
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rd_base <= {AW{1'b0}};
         iss_left <= 3'd0;
         iss_idx <= 2'd0;
         pend <= 1'b0;
         pend_addr <= {AW{1'b0}};
      end else begin
         pend <= iss;
         if (iss) begin
            pend_addr <= rd_addr;
         end
         if (rd_cmd) begin
            rd_base <= s_addr;
            iss_left <= 3'd4;
            iss_idx <= 2'd0;
         end else if (iss) begin
            iss_left <= iss_left - 3'd1;
            iss_idx <= iss_idx + 2'd1;
         end
      end
   end

   qds_mem #(.AW(AW), .DW(DW), .LN(LN)) u_mem (
      .mclk(mclk),
      .we(cm_we),
      .waddr(cm_addr),
      .wdata(cm_data),
      .wbe(cm_be),
      .raddr(rd_addr),
      .rdata(mem_rdata)
   );

   // ----------------------------------------------------------------
   // output stage and echo clocks
   // ----------------------------------------------------------------
   reg [RL-1:0] rsh;
   reg [1:0] out_left;
   wire pop_k = k_rise & (rsh[RL-1] | out_left == 2'd2);
   wire pop_kn = kn_rise & (out_left == 2'd3 | out_left == 2'd1);
   wire pop = (pop_k | pop_kn) & f_out_valid;

   qds_fifo #(.WIDTH(DW), .DEPTH(FDEPTH), .PW(FPW)) u_fifo (
      .mclk(mclk),
      .resetn(resetn),
      .in_valid(pend),
      .in_ready(f_in_ready),
      .in_data(merged),
      .out_valid(f_out_valid),
      .out_ready(pop),
      .out_data(f_out_data)
   );

   // beats leave on true, comp, true, comp rises; echo tracks them
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rsh <= {RL{1'b0}};
         out_left <= 2'd0;
         read_data_out <= {DW{1'b0}};
         echo_clock_true <= 1'b0;
         echo_clock_comp <= 1'b1;
      end else begin
         if (k_rise) begin
            rsh <= {rsh[RL-2:0], rd_cmd};
            echo_clock_true <= 1'b1;
            echo_clock_comp <= 1'b0;
            if (rsh[RL-1]) begin
               out_left <= 2'd3;
            end else if (out_left == 2'd2) begin
               out_left <= 2'd1;
            end
         end else if (kn_rise) begin
            echo_clock_true <= 1'b0;
            echo_clock_comp <= 1'b1;
            if (out_left == 2'd3) begin
               out_left <= 2'd2;
            end else if (out_left == 2'd1) begin
               out_left <= 2'd0;
            end
         end
         if (pop) begin
            read_data_out <= f_out_data;
         end
      end
   end
endmodule // qds_sram_ports

// ==== bench/qds_sram_chk.sv ====
// checker for the sram port pins, one mclk domain
// assumes: bound into qds_sram_ports, k pins sampled by mclk
`timescale 1ns/1ps
module qds_sram_chk #(
   parameter DW = 36
) (
   input wire mclk, // system clock
   input wire resetn, // async reset, low
   input wire k_clk, // true input clock
   input wire k_clk_n, // complement input clock
   input wire read_sel_n, // read select, low
   input wire write_sel_n, // write select, low
   input wire [DW-1:0] read_data_out, // read beat
   input wire echo_clock_true, // echo clock
   input wire echo_clock_comp // echo clock, inverted
);
   reg k_q;
   reg [4:0] rd_hist;
   reg [2:0] settle; // cycles since reset, until the pin filter is full
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // one bit per k rise: was a read issued there
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         k_q <= 1'b0;
         rd_hist <= 5'h00;
         settle <= 3'h0;
      end else begin
         k_q <= k_clk;
         if (settle != 3'h7) settle <= settle + 3'h1;
         if (k_clk && !k_q) rd_hist <= {rd_hist[3:0], !read_sel_n};
      end
   end
   echo_pair_a: assert property (echo_clock_comp == !echo_clock_true)
      else $error("echo clocks not complementary");
   // pin edges just around reset release are not seen by the design
   echo_rise_a: assert property (settle == 3'h7 && $rose(k_clk)
      |-> ##[2:6] $rose(echo_clock_true))
      else $error("echo clock missed a k rise");
   echo_fall_a: assert property (settle == 3'h7 && $rose(k_clk_n)
      |-> ##[2:6] $fell(echo_clock_true))
      else $error("echo clock missed a k_n rise");
   echo_high_a: assert property ($rose(echo_clock_true)
      |=> echo_clock_true [*3])
      else $error("echo high phase too short");
   echo_low_a: assert property ($fell(echo_clock_true)
      |=> !echo_clock_true [*3])
      else $error("echo low phase too short");
   data_echo_a: assert property ($changed(read_data_out)
      |-> $changed(echo_clock_true))
      else $error("read data moved off an echo edge");
   beat_rise_a: assert property ($changed(read_data_out)
      && $rose(echo_clock_true) |-> |rd_hist[3:2])
      else $error("odd beat without a read two or three k rises back");
   beat_fall_a: assert property ($changed(read_data_out)
      && $fell(echo_clock_true) |-> |rd_hist[4:2])
      else $error("even beat without a read in flight");
   cover property ($rose(echo_clock_true) && rd_hist[2]);
   cover property ($rose(k_clk) && !write_sel_n);
   cover property ($rose(k_clk) && !write_sel_n && rd_hist[0]);
endmodule // qds_sram_chk

bind qds_sram_ports qds_sram_chk #(.DW(DW)) u_chk (.mclk(mclk), .resetn(resetn),
   .k_clk(k_clk), .k_clk_n(k_clk_n), .read_sel_n(read_sel_n),
   .write_sel_n(write_sel_n), .read_data_out(read_data_out),
   .echo_clock_true(echo_clock_true), .echo_clock_comp(echo_clock_comp));

// ==== bench/qds_ctrl_model.sv ====
// memory controller model: k clock pair, commands and late write beats
// assumes: caller queues one entry per k cycle, reads every other cycle
`timescale 1ns/1ps
module qds_ctrl_model (
   input wire mclk, // system clock, pins move on its fall
   output logic k_clk, // true clock, 48 ns
   output logic k_clk_n, // complement clock
   output logic read_sel_n, // read select
   output logic write_sel_n, // write select
   output logic [18:0] sync_address_in, // command address
   output logic [35:0] write_data_in, // write beat
   output logic [3:0] byte_lane_write_n // lane enables, low
);
   logic [180:0] cmd_q[$]; // kind 1 read 2 write, addr, data, lanes
   logic [180:0] c, wr_next, wr_cur;
   logic wr_pend = 1'b0;
   logic wr_arm = 1'b0; // command out, first beat due next k rise
   logic is_k;
   int beat = 4;
   task automatic push(input logic [180:0] e);
      cmd_q.push_back(e);
   endtask
   // free-running opposite-phase pair, offset from mclk
   initial begin
      k_clk = 1'b0;
      k_clk_n = 1'b1;
      read_sel_n = 1'b1;
      write_sel_n = 1'b1;
      #0.7;
      forever begin
         #24;
         k_clk = ~k_clk;
         k_clk_n = ~k_clk_n;
      end
   end
   // pins change well after each edge, held through sampling
   always @(posedge k_clk or posedge k_clk_n) begin
      is_k = k_clk;
      #17;
      @(negedge mclk);
      // beat one is set up after the k_n rise, for the next k rise
      if (!is_k && wr_arm) begin
         wr_cur = wr_next;
         wr_arm = 1'b0;
         beat = 0;
      end
      if (beat < 4) begin
         write_data_in = wr_cur[16+36*beat +: 36];
         byte_lane_write_n = wr_cur[4*beat +: 4];
         beat++;
      end else begin
         write_data_in = 36'({$urandom(), $urandom()});
         byte_lane_write_n = 4'($urandom());
      end
      if (is_k) begin
         // the write command stands at the coming k rise
         wr_arm = wr_pend;
         wr_pend = 1'b0;
         c = (cmd_q.size() != 0) ? cmd_q.pop_front() : '0;
         read_sel_n = (c[180:179] != 2'd1);
         write_sel_n = (c[180:179] != 2'd2);
         sync_address_in = c[180:179] != 0 ? c[178:160] : 19'($urandom());
         if (c[180:179] == 2'd2) begin
            wr_next = c;
            wr_pend = 1'b1;
         end
      end
   end
endmodule // qds_ctrl_model

// ==== bench/tb_qds_sram_ports.sv ====
// bench for the sram ports: writes, byte lanes, coherent reads
// assumes: controller model on the pins, design at default sizes
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("Error at %0t: got %h exp %h", $time, g, e); end end
module tb_qds_sram_ports;
   localparam logic [18:0] BASE = 19'h7ffec; // eight groups, wraps
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   wire k_clk, k_clk_n, read_sel_n, write_sel_n;
   wire echo_clock_true, echo_clock_comp;
   wire [18:0] sync_address_in;
   wire [35:0] write_data_in, read_data_out;
   wire [3:0] byte_lane_write_n;
   logic [35:0] ref_mem [logic [18:0]];
   logic [35:0] exp_q[$];
   logic [1:0] rd_hist = 2'b00;
   int n_mismatch = 0;
   int n_checks = 0;
   int wp, wq, rg;
   always #2.5 mclk = ~mclk;
   qds_ctrl_model u_model (.mclk(mclk), .k_clk(k_clk), .k_clk_n(k_clk_n),
      .read_sel_n(read_sel_n), .write_sel_n(write_sel_n),
      .sync_address_in(sync_address_in), .write_data_in(write_data_in),
      .byte_lane_write_n(byte_lane_write_n));
   qds_sram_ports u_dut (.mclk(mclk), .resetn(resetn), .k_clk(k_clk),
      .k_clk_n(k_clk_n), .read_sel_n(read_sel_n), .write_sel_n(write_sel_n),
      .sync_address_in(sync_address_in), .write_data_in(write_data_in),
      .byte_lane_write_n(byte_lane_write_n), .read_data_out(read_data_out),
      .echo_clock_true(echo_clock_true), .echo_clock_comp(echo_clock_comp));
   // queue a write burst and fold its enabled lanes into the reference
   task automatic do_wr(input int g, input bit full);
      logic [18:0] a;
      logic [143:0] d;
      logic [15:0] be;
      a = BASE + 19'(g * 4);
      for (int i = 0; i < 16; i++) begin
         d[9*i +: 9] = 9'($urandom());
         be[i] = full ? 1'b0 : 1'($urandom());
         if (!be[i]) ref_mem[a + 19'(i / 4)][9*(i%4) +: 9] = d[9*i +: 9];
      end
      u_model.push({2'd2, a, d, be});
   endtask
   // queue a read burst and note its four expected beats
   task automatic do_rd(input int g);
      logic [18:0] a;
      a = BASE + 19'(g * 4);
      for (int i = 0; i < 4; i++) exp_q.push_back(ref_mem[a + 19'(i)]);
      u_model.push({2'd1, a, 160'h0});
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // each beat lands on an echo edge; compare against oldest note
   task automatic check_burst;
      logic [35:0] e;
      for (int i = 0; i < 4; i++) begin
         if (i % 2 == 0) @(posedge echo_clock_true);
         else @(posedge echo_clock_comp);
         @(negedge mclk);
         e = exp_q.pop_front();
         `CHK(read_data_out, e)
      end
   endtask
   // a read seen at k rise c is checked from k rise c+2 on
   always @(posedge k_clk) rd_hist <= {rd_hist[0], !read_sel_n};
   always @(posedge k_clk) begin
      if (rd_hist[1] === 1'b1) fork check_burst(); join_none
   end
   // watchdog
   initial begin
      #30000;
      n_mismatch++;
      $display("Error at %0t: run timed out", $time);
      finish_test();
   end
   // main sequence
   initial begin
      void'($urandom(66694));
      repeat (10) @(negedge mclk);
      `CHK(read_data_out, 36'h0)
      `CHK({echo_clock_true, echo_clock_comp}, 2'b01)
      resetn = 1'b1;
      repeat (8) @(negedge mclk);
      for (int g = 0; g < 8; g++) begin
         do_wr(g, 1'b1);
         u_model.push('0);
      end
      wp = 7;
      for (int k = 0; k < 80; k++) begin
         wq = wp;
         wp = $urandom_range(7);
         do_wr(wp, 1'b0);
         rg = $urandom_range(1) ? wq : $urandom_range(7);
         while (rg == wp) rg = $urandom_range(7);
         do_rd(rg);
      end
      repeat (3) u_model.push('0);
      for (int g = 0; g < 8; g++) begin
         do_rd(g);
         u_model.push('0);
      end
      for (int i = 0; i < 4000 && exp_q.size() != 0; i++) @(negedge mclk);
      `CHK(exp_q.size(), 0)
      finish_test();
   end
endmodule // tb_qds_sram_ports
